/* File: irq_consts.svh */
// Offsets, field positions, reset values and vectors of the interrupt controller.
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
`define ADDR_ACCEPT_LOW   8'h3A
`define ADDR_ACCEPT_HIGH  8'h3B
`define ADDR_LATCH_LOW    8'h3C
`define ADDR_LATCH_HIGH   8'h3D
`define ADDR_LEVEL_SELECT 8'h3E
`define ADDR_WATCH_CTRL   8'h3F
`define GLOBAL_ACCEPT_BIT 0
`define TRAP_CHOICE_BIT   0
`define TIMEOUT_CHOICE_BIT 1
`define WATCH_CTRL_RESET  8'h03
`define LATCH_TRAP_BIT    2
`define LATCH_WATCH_BIT   3
`define FIRST_MASKABLE    5
`define LAST_LEVEL        15
`define VEC_RESET         16'hFFFE
`define VEC_SOFT          16'hFFFC
`define VEC_TRAP          16'hFFFA
`define VEC_WATCH         16'hFFF8
`define VEC_LEVEL5        16'hFFF4
`define SEL_L8_BIT        7
`define SEL_L12_BIT       3
`define SEL_L13_BIT       2
`define SEL_L14_BIT       1
`define SEL_L15_BIT       0
`endif

/* File: irq_pkg.sv */
// Types shared by the interrupt controller files.
package irq_pkg;
  typedef logic [15:0] vector_t;
  typedef logic [7:0]  sfr_byte_t;
  typedef logic [7:0]  sfr_addr_t;
endpackage : irq_pkg

/* File: priority_pick.sv */
// Fixed-priority resolver that turns a request word into a vector.
`timescale 1ns/1ns
`include "irq_consts.svh"
module priority_pick
  import irq_pkg::*;
(
  input  wire logic [15:0]     request_i,
  input  wire logic            soft_i,
  output logic                 any_o,
  output logic [3:0]           level_o,
  output irq_pkg::vector_t     vector_o
);
  // ==========================================================
  // Resolver
  always_comb begin
    any_o    = 1'b0;
    level_o  = 4'h0;
    vector_o = `VEC_RESET;
    for (int n = `LAST_LEVEL; n >= `FIRST_MASKABLE; n--) begin
      if (request_i[n]) begin
        any_o    = 1'b1;
        level_o  = 4'(n);
        vector_o = 16'(`VEC_LEVEL5 - 16'(2 * (n - `FIRST_MASKABLE)));
      end
    end
    if (request_i[`LATCH_WATCH_BIT]) begin
      any_o    = 1'b1;
      level_o  = 4'(`LATCH_WATCH_BIT);
      vector_o = `VEC_WATCH;
    end
    if (request_i[`LATCH_TRAP_BIT]) begin
      any_o    = 1'b1;
      level_o  = 4'(`LATCH_TRAP_BIT);
      vector_o = `VEC_TRAP;
    end
    if (soft_i) begin
      any_o    = 1'b1;
      level_o  = 4'h0;
      vector_o = `VEC_SOFT;
    end
  end
endmodule : priority_pick

/* File: prioritized_interrupt_latch_controller.sv */
// Interrupt latch, enable and priority logic with its special-function registers.
`timescale 1ns/1ns
`include "irq_consts.svh"
module prioritized_interrupt_latch_controller
  import irq_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire irq_pkg::sfr_addr_t sfr_addr_i,
  input  wire irq_pkg::sfr_byte_t sfr_wdata_i,
  input  wire logic              sfr_write_i,
  input  wire logic              sfr_read_i,
  output irq_pkg::sfr_byte_t     sfr_rdata_o,
  input  wire logic              software_trap_i,
  input  wire logic              bad_opcode_trap_i,
  input  wire logic              fetch_guard_trap_i,
  input  wire logic              watch_timeout_irq_i,
  input  wire logic              ext_input_one_i,
  input  wire logic              ext_input_two_i,
  input  wire logic              ext_input_three_i,
  input  wire logic              ext_input_four_i,
  input  wire logic              ext_input_five_i,
  input  wire logic              time_base_irq_i,
  input  wire logic              counter_one_irq_i,
  input  wire logic              counter_zero_irq_i,
  input  wire logic              serial0_rx_irq_i,
  input  wire logic              serial0_tx_irq_i,
  input  wire logic              serial1_rx_irq_i,
  input  wire logic              serial1_tx_irq_i,
  input  wire logic              sync_serial_irq_i,
  input  wire logic              event_timer_irq_i,
  input  wire logic              capture_irq_i,
  input  wire logic              compare_irq_i,
  input  wire logic              boundary_i,
  input  wire logic              return_i,
  output logic                   accept_o,
  output irq_pkg::vector_t       vector_o,
  output logic                   reset_request_o
);
  // ==========================================================
  // State
  logic [15:0] pending_latch_reg;
  logic [15:0] pending_latch_next;
  logic [15:0] accept_enable_reg;
  logic [7:0]  shared_level_select_reg;
  logic [7:0]  watch_control_one_reg;
  logic [7:0]  accept_stack_reg;
  logic [7:0]  accept_stack_next;
  logic        accept_reg;
  vector_t     vector_reg;
  logic        reset_request_reg;
  sfr_byte_t   rdata_reg;
  sfr_byte_t   rdata_next;

  // ==========================================================
  // Source steering and decode
  logic [15:0] raise;
  logic [15:0] write_clear;
  logic [15:0] enabled_req;
  logic [15:0] accepted_bit;
  logic        global_accept_flag;
  logic        trap_as_irq;
  logic        watch_as_irq;
  logic        soft_req;
  logic        pick_any;
  logic [3:0]  pick_level;
  vector_t     pick_vector;
  logic        take;
  logic        wr_enl;
  logic        wr_enh;
  logic        wr_ll;
  logic        wr_lh;
  logic        wr_sel;
  logic        wr_wdc;

  assign global_accept_flag = accept_enable_reg[`GLOBAL_ACCEPT_BIT];
  assign trap_as_irq  = ~watch_control_one_reg[`TRAP_CHOICE_BIT];
  assign watch_as_irq = ~watch_control_one_reg[`TIMEOUT_CHOICE_BIT];
  assign soft_req     = software_trap_i | bad_opcode_trap_i;

  assign raise[1:0] = 2'b00;
  assign raise[4]   = 1'b0;
  assign raise[`LATCH_TRAP_BIT]  = fetch_guard_trap_i & trap_as_irq;
  assign raise[`LATCH_WATCH_BIT] = watch_timeout_irq_i & watch_as_irq;
  assign raise[5]  = ext_input_one_i;
  assign raise[6]  = time_base_irq_i;
  assign raise[7]  = counter_one_irq_i;
  assign raise[8]  = shared_level_select_reg[`SEL_L8_BIT]
                     ? sync_serial_irq_i : serial0_rx_irq_i;
  assign raise[9]  = serial0_tx_irq_i;
  assign raise[10] = event_timer_irq_i;
  assign raise[11] = capture_irq_i;
  assign raise[12] = shared_level_select_reg[`SEL_L12_BIT]
                     ? ext_input_two_i : compare_irq_i;
  assign raise[13] = shared_level_select_reg[`SEL_L13_BIT]
                     ? serial1_rx_irq_i : ext_input_three_i;
  assign raise[14] = shared_level_select_reg[`SEL_L14_BIT]
                     ? serial1_tx_irq_i : ext_input_four_i;
  assign raise[15] = shared_level_select_reg[`SEL_L15_BIT]
                     ? ext_input_five_i : counter_zero_irq_i;

  assign wr_enl = sfr_write_i && sfr_addr_i == `ADDR_ACCEPT_LOW;
  assign wr_enh = sfr_write_i && sfr_addr_i == `ADDR_ACCEPT_HIGH;
  assign wr_ll  = sfr_write_i && sfr_addr_i == `ADDR_LATCH_LOW;
  assign wr_lh  = sfr_write_i && sfr_addr_i == `ADDR_LATCH_HIGH;
  assign wr_sel = sfr_write_i && sfr_addr_i == `ADDR_LEVEL_SELECT;
  assign wr_wdc = sfr_write_i && sfr_addr_i == `ADDR_WATCH_CTRL;

  // A zero written clears; a one leaves the latch alone.
  assign write_clear = {wr_lh ? ~sfr_wdata_i : 8'h00,
                        wr_ll ? ~sfr_wdata_i : 8'h00};

  // Traps pass regardless of enables; maskable levels need both flags.
  assign enabled_req[3:0]  = {pending_latch_reg[3:2], 2'b00};
  assign enabled_req[4]    = 1'b0;
  assign enabled_req[15:5] = pending_latch_reg[15:5] & accept_enable_reg[15:5]
                             & {11{global_accept_flag}};

  priority_pick u_pick (
    .request_i (enabled_req),
    .soft_i    (soft_req),
    .any_o     (pick_any),
    .level_o   (pick_level),
    .vector_o  (pick_vector)
  );

  assign take = boundary_i & pick_any;
  assign accepted_bit = (take && pick_level != 4'h0) ? (16'h0001 << pick_level) : 16'h0000;

  // Set wins over both write clear and acceptance clear.
  assign pending_latch_next = (pending_latch_reg & ~write_clear & ~accepted_bit)
                              | raise;

  // ==========================================================
  // Global accept stacking: push on accept, pop on return.
  assign accept_stack_next = take ? {accept_stack_reg[6:0], global_accept_flag}
                           : return_i ? {1'b0, accept_stack_reg[7:1]}
                           : accept_stack_reg;

  // ==========================================================
  // Read data
  always_comb begin
    unique case (sfr_addr_i)
      `ADDR_ACCEPT_LOW:   rdata_next = accept_enable_reg[7:0];
      `ADDR_ACCEPT_HIGH:  rdata_next = accept_enable_reg[15:8];
      `ADDR_LATCH_LOW:    rdata_next = pending_latch_reg[7:0];
      `ADDR_LATCH_HIGH:   rdata_next = pending_latch_reg[15:8];
      `ADDR_LEVEL_SELECT: rdata_next = shared_level_select_reg;
      `ADDR_WATCH_CTRL:   rdata_next = watch_control_one_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pending_latch_reg <= 16'h0000;
    end else begin
      pending_latch_reg <= pending_latch_next;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      accept_enable_reg <= 16'h0000;
    end else if (take) begin
      accept_enable_reg[`GLOBAL_ACCEPT_BIT] <= 1'b0;
    end else if (return_i) begin
      accept_enable_reg[`GLOBAL_ACCEPT_BIT] <= accept_stack_reg[0];
    end else if (wr_enl) begin
      accept_enable_reg[7:0] <= sfr_wdata_i & 8'hF1;
    end else if (wr_enh) begin
      accept_enable_reg[15:8] <= sfr_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      shared_level_select_reg <= 8'h00;
      watch_control_one_reg   <= `WATCH_CTRL_RESET;
    end else begin
      if (wr_sel) begin
        shared_level_select_reg <= sfr_wdata_i & 8'h8F;
      end
      if (wr_wdc) begin
        watch_control_one_reg <= sfr_wdata_i & 8'h03;
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      accept_stack_reg  <= 8'h00;
      accept_reg        <= 1'b0;
      vector_reg        <= `VEC_RESET;
      reset_request_reg <= 1'b0;
      rdata_reg         <= 8'h00;
    end else begin
      accept_stack_reg  <= accept_stack_next;
      accept_reg        <= take;
      vector_reg        <= take ? pick_vector : vector_reg;
      reset_request_reg <= (fetch_guard_trap_i & ~trap_as_irq)
                           | (watch_timeout_irq_i & ~watch_as_irq);
      rdata_reg         <= sfr_read_i ? rdata_next : rdata_reg;
    end
  end

  assign accept_o        = accept_reg;
  assign vector_o        = vector_reg;
  assign reset_request_o = reset_request_reg;
  assign sfr_rdata_o     = rdata_reg;
endmodule : prioritized_interrupt_latch_controller

/* File: irq_assertions.sv */
// Port checker for the interrupt controller.
`timescale 1ns/1ns
module irq_assertions
  import irq_pkg::*;
(
  input wire logic               clock_i,
  input wire logic               reset_i,
  input wire irq_pkg::sfr_addr_t sfr_addr_i,
  input wire logic               sfr_read_i,
  input wire irq_pkg::sfr_byte_t sfr_rdata_o,
  input wire logic               software_trap_i,
  input wire logic               bad_opcode_trap_i,
  input wire logic               boundary_i,
  input wire logic               accept_o,
  input wire irq_pkg::vector_t   vector_o
);
  wire logic mapped = sfr_addr_i >= 8'h3A && sfr_addr_i <= 8'h3F;
  wire logic masked = accept_o && vector_o <= 16'hFFF4;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Relations between the ports.
  accept_boundary_a: assert property (accept_o |-> $past(boundary_i))
    else $error("accept outside a boundary");
  soft_vector_a: assert property (boundary_i && (software_trap_i || bad_opcode_trap_i)
    |=> accept_o && vector_o == 16'hFFFC) else $error("soft trap not taken");
  vector_hold_a: assert property (!accept_o |-> $stable(vector_o))
    else $error("vector moved without accept");
  vector_legal_a: assert property (accept_o |-> vector_o inside {16'hFFFC, 16'hFFFA,
    16'hFFF8} || (vector_o >= 16'hFFE0 && masked && !vector_o[0])) else $error("bad vector");
  unmapped_zero_a: assert property (sfr_read_i && !mapped |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!sfr_read_i |=> $stable(sfr_rdata_o))
    else $error("read data moved");
  accept_pad_a: assert property (sfr_read_i && sfr_addr_i == 8'h3A
    |=> sfr_rdata_o[3:1] == 3'h0) else $error("accept pad bits set");
  select_pad_a: assert property (sfr_read_i && sfr_addr_i == 8'h3E
    |=> sfr_rdata_o[6:4] == 3'h0) else $error("select pad bits set");
  mask_repeat_a: assert property (masked |=> !masked)
    else $error("maskable taken twice");
endmodule : irq_assertions
bind prioritized_interrupt_latch_controller irq_assertions chk_u (.clock_i(clock_i),
  .reset_i(reset_i), .sfr_addr_i(sfr_addr_i), .sfr_read_i(sfr_read_i),
  .sfr_rdata_o(sfr_rdata_o), .software_trap_i(software_trap_i),
  .bad_opcode_trap_i(bad_opcode_trap_i), .boundary_i(boundary_i), .accept_o(accept_o),
  .vector_o(vector_o));

/* File: cpu_core_model.sv */
// Behavioural CPU core that takes interrupts at instruction boundaries.
`timescale 1ns/1ns
module cpu_core_model (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       run_i,
  input  wire logic [1:0] trap_i,
  input  wire logic       accept_i,
  output logic            boundary_o,
  output logic            software_trap_o,
  output logic            bad_opcode_trap_o
);
  logic [1:0] held_reg;
  // ==========================================================
  // Trap requests stay up until accepted; no boundary while the vector is fetched.
  assign boundary_o = run_i & ~accept_i;
  assign software_trap_o = held_reg[0] & ~accept_i;
  assign bad_opcode_trap_o = held_reg[1] & ~accept_i;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) held_reg <= 2'h0;
    else if (accept_i) held_reg <= trap_i;
    else held_reg <= held_reg | trap_i;
  end
endmodule : cpu_core_model

/* File: tb.sv */
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ns
module tb;
  import irq_pkg::*;
  logic clock_i = 0, reset_i = 1, wr = 0, rd = 0, run = 0, ret = 0, fg = 0, wt = 0;
  logic acc, rreq, bnd, sw, bo;
  logic [1:0] trap = 2'h0;
  logic [15:0] src = 16'h0, alt = 16'h0;
  sfr_addr_t addr = 8'h00;
  sfr_byte_t wdata = 8'h00, rdata;
  vector_t vec;
  int failures = 0, compares = 0;
  always #10 clock_i = ~clock_i;
  cpu_core_model cpu_u (.clock_i(clock_i), .reset_i(reset_i), .run_i(run), .trap_i(trap),
    .accept_i(acc), .boundary_o(bnd), .software_trap_o(sw), .bad_opcode_trap_o(bo));
  prioritized_interrupt_latch_controller dut_u (.clock_i(clock_i), .reset_i(reset_i),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_write_i(wr), .sfr_read_i(rd),
    .sfr_rdata_o(rdata), .software_trap_i(sw), .bad_opcode_trap_i(bo),
    .fetch_guard_trap_i(fg), .watch_timeout_irq_i(wt), .ext_input_one_i(src[5]),
    .ext_input_two_i(alt[12]), .ext_input_three_i(src[13]), .ext_input_four_i(src[14]),
    .ext_input_five_i(alt[15]), .time_base_irq_i(src[6]), .counter_one_irq_i(src[7]),
    .counter_zero_irq_i(src[15]), .serial0_rx_irq_i(src[8]), .serial0_tx_irq_i(src[9]),
    .serial1_rx_irq_i(alt[13]), .serial1_tx_irq_i(alt[14]), .sync_serial_irq_i(alt[8]),
    .event_timer_irq_i(src[10]), .capture_irq_i(src[11]), .compare_irq_i(src[12]),
    .boundary_i(bnd), .return_i(ret), .accept_o(acc), .vector_o(vec), .reset_request_o(rreq));
  // ==========================================================
  // Shared bus cycles and checks.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sfr(input logic w, input sfr_addr_t a, input sfr_byte_t d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : sfr
  task automatic pulse(input logic [15:0] s, input logic [15:0] a, input logic [1:0] t);
    @(posedge clock_i);
    src <= s;
    alt <= a;
    {wt, fg} <= t;
    @(posedge clock_i);
    src <= 16'h0;
    alt <= 16'h0;
    {wt, fg} <= 2'h0;
  endtask : pulse
  task automatic take(input vector_t exp);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (acc !== 1'b1 && n < 20);
    chk(acc, 1'b1);
    chk(vec, exp);
  endtask : take
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Scenarios.
  task automatic t_regs;
    sfr(0, 8'h3C, 0); chk(rdata, 8'h00);
    sfr(0, 8'h3A, 0); chk(rdata, 8'h00);
    sfr(0, 8'h10, 0); chk(rdata, 8'h00);
    chk(vec, 16'hFFFE);
    pulse(16'h0020, 0, 0);
    sfr(0, 8'h3C, 0); chk(rdata, 8'h20);
    sfr(1, 8'h3C, 8'h2C);
    sfr(0, 8'h3C, 0); chk(rdata, 8'h20);
    sfr(1, 8'h3C, 8'h0C);
    sfr(0, 8'h3C, 0); chk(rdata, 8'h00);
  endtask : t_regs
  task automatic t_levels;
    run <= 1'b1;
    sfr(1, 8'h3A, 8'h01);
    pulse(16'h0040, 0, 0);
    sfr(0, 8'h3C, 0); chk(rdata, 8'h40);
    sfr(1, 8'h3A, 8'h40);
    sfr(0, 8'h3C, 0); chk(rdata, 8'h40);
    sfr(1, 8'h3B, 8'hFF);
    for (int n = 5; n < 16; n++) begin
      if (n != 6) pulse(16'h1 << n, 0, 0);
      sfr(1, 8'h3A, 8'hF1);
      take(16'hFFF4 - 16'(2 * (n - 5)));
      sfr(0, 8'h3D, 0); chk(rdata, 8'h00);
      sfr(0, 8'h3A, 0); chk(rdata, 8'hF0);
    end
    @(posedge clock_i) ret <= 1'b1;
    @(posedge clock_i) ret <= 1'b0;
    sfr(0, 8'h3A, 0); chk(rdata, 8'hF1);
    sfr(1, 8'h3A, 8'hF0);
    @(posedge clock_i) trap <= 2'h1;
    @(posedge clock_i) trap <= 2'h2;
    take(16'hFFFC);
    @(posedge clock_i) trap <= 2'h0;
    take(16'hFFFC);
  endtask : t_levels
  task automatic t_order;
    run <= 1'b0;
    sfr(1, 8'h3F, 8'h00);
    pulse(16'h8040, 0, 2'h3);
    sfr(1, 8'h3A, 8'hF1);
    run <= 1'b1;
    take(16'hFFFA);
    take(16'hFFF8);
    sfr(1, 8'h3A, 8'hF1);
    take(16'hFFF2);
    sfr(1, 8'h3A, 8'hF1);
    take(16'hFFE0);
    sfr(1, 8'h3E, 8'h8F);
    pulse(16'hF100, 0, 0);
    sfr(0, 8'h3D, 0); chk(rdata, 8'h00);
    pulse(0, 16'hF100, 0);
    sfr(0, 8'h3D, 0); chk(rdata, 8'hF1);
    sfr(0, 8'h3E, 0); chk(rdata, 8'h8F);
  endtask : t_order
  task automatic t_reset_route(input logic [1:0] t);
    @(posedge clock_i) reset_i <= 1'b1;
    @(posedge clock_i) reset_i <= 1'b0;
    pulse(0, 0, t);
    #1 chk(rreq, 1'b1);
  endtask : t_reset_route
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs;
    t_levels;
    t_order;
    t_reset_route(2'h1);
    t_reset_route(2'h2);
    end_sim;
  end
  initial begin
    #400000;
    failures++;
    end_sim;
  end
endmodule : tb
